//--- core/pprp_regs.sv
// Paged configuration and status register bank of a three-port cable PHY.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Strap sampled at reset sets all sleep enables.
// - Each port sleep enable written on its own.
// - Monitor mode shows port sleep states on data.
// - Loop-block flag cleared on bus reset, disconnect.
// - Standby flag follows standby state exactly.
// - Forced-off acts only while port disabled.
// - Forced-off disabled port drops flags and tones.
// - Release from forced-off triggers speed renegotiation.
// - Page select 1 maps identification page.
// - Conformance register reads 02h at address 1000.
// - Maker code MSB at 1010b, three bytes.
// - Part code MSB at 1101b, three bytes.
// - Page select 7 maps vendor-dependent page.
// - Soft hard-reset write resets whole device.
// - Soft hard-reset bit always reads zero.
module pprp_regs #(
  parameter int          NUM_PORTS  = pprp_pkg::NUM_PORTS,
  // Arbitrary neutral identification values.
  parameter logic [23:0] MAKER_CODE = 24'h123456,
  parameter logic [23:0] PART_CODE  = 24'h654321
) (
  // Clock and reset.
  input  wire logic                   SYS_CLK,
  input  wire logic                   RESET_N,
  // Register port from the link controller.
  input  wire logic [3:0]             REG_ADDR,
  input  wire logic [7:0]             REG_WDATA,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  output logic      [7:0]             REG_RDATA,
  // Straps and modes.
  input  wire logic                   SLEEP_STRAP_PIN,
  input  wire logic                   LINK_CLOCK_MONITOR_PIN,
  // Per-port state from the port logic.
  input  wire logic [NUM_PORTS-1:0]   PORT_CON_RAW,
  input  wire logic [NUM_PORTS-1:0]   PORT_RECEIVE_OK_FLAG_RAW,
  input  wire logic [NUM_PORTS-1:0]   PORT_LOOP_BLOCK,
  input  wire logic [NUM_PORTS-1:0]   PORT_DISCONNECT,
  input  wire logic                   BUS_RESET,
  input  wire logic [NUM_PORTS-1:0]   PORT_STANDBY,
  input  wire logic [NUM_PORTS-1:0]   PORT_SLEEPING,
  input  wire logic [NUM_PORTS-1:0]   PORT_DISABLED,
  // Per-port controls back to the port logic.
  output logic      [NUM_PORTS-1:0]   PORT_CON,
  output logic      [NUM_PORTS-1:0]   RECEIVE_OK_FLAG,
  output logic      [NUM_PORTS-1:0]   PORT_TONE_EN,
  output logic      [NUM_PORTS-1:0]   PORT_RENEGOTIATE,
  output logic      [NUM_PORTS-1:0]   PORT_SLEEP_EN,
  // Device-wide reset to the rest of the PHY.
  output logic                        DEVICE_RESET,
  // Monitor data lines.
  output logic      [7:0]             DATA_OUT,
  output logic                        DATA_OE_N
);

  // Internal state.
  logic                   rst;
  logic                   soft_rst_r;
  logic [7:0]             base_sel_r;
  logic [NUM_PORTS-1:0]   sleep_en_r;
  logic [NUM_PORTS-1:0]   hard_off_r;
  logic [NUM_PORTS-1:0]   loop_blk_r;
  logic [NUM_PORTS-1:0]   standby_r;
  logic [NUM_PORTS-1:0]   forced_off_r;
  logic [7:0]             rdata_r;
  logic [NUM_PORTS-1:0]   con_r;
  logic [NUM_PORTS-1:0]   receive_ok_flag_r;
  logic [NUM_PORTS-1:0]   tone_r;
  logic [NUM_PORTS-1:0]   reneg_r;
  logic [7:0]             data_out_r;
  logic                   data_oe_n_r;
  logic                   dev_rst_r;
  logic                   rst_dly_r;

  // Decoded selections.
  wire logic [2:0]        page_sel;
  wire logic [3:0]        port_sel;
  wire logic              port_ok;
  wire logic              paged;
  wire logic              on_port_pg;
  wire logic              on_ident_pg;
  wire logic              on_vendor_pg;
  wire logic              wr_base_sel;
  wire logic              wr_port_ctl;
  wire logic              wr_soft_rst;
  wire logic [NUM_PORTS-1:0] port_hit;
  wire logic [NUM_PORTS-1:0] forced_off;
  wire logic [NUM_PORTS-1:0] loop_clr;
  wire logic [7:0]        port_byte;
  wire logic [7:0]        ident_byte;
  wire logic [7:0]        rd_mux;
  wire logic [7:0]        sleep_view;
  wire logic              monitor_on;
  wire logic              chk_off;

  // Returns one bit of a port vector, zero for an absent port.
  function automatic logic port_bit(input logic [NUM_PORTS-1:0] vec, input logic [3:0] idx);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (idx == i[3:0]) begin
        r = vec[i];
      end
    end
    return r;
  endfunction

  // Hardware reset and soft hard reset act the same way.
  assign rst = !RESET_N || soft_rst_r;

  // Address and page decode.
  assign page_sel     = base_sel_r[pprp_pkg::PAGE_LSB +: pprp_pkg::PAGE_W];
  assign port_sel     = base_sel_r[pprp_pkg::PORT_LSB +: pprp_pkg::PORT_W];
  assign port_ok      = (port_sel < 4'(NUM_PORTS));
  assign paged        = REG_ADDR[3];
  assign on_port_pg   = paged && (page_sel == pprp_pkg::PAGE_PORT);
  assign on_ident_pg  = paged && (page_sel == pprp_pkg::PAGE_IDENT);
  assign on_vendor_pg = paged && (page_sel == pprp_pkg::PAGE_VENDOR);
  assign wr_base_sel  = REG_WR && (REG_ADDR == pprp_pkg::BASE_SEL_ADDR);
  assign wr_port_ctl  = REG_WR && on_port_pg && port_ok
                        && (REG_ADDR == pprp_pkg::PORT_CTL_ADDR);
  assign wr_soft_rst  = REG_WR && on_vendor_pg && (REG_ADDR == pprp_pkg::SOFT_RST_ADDR)
                        && REG_WDATA[pprp_pkg::SOFT_RST_BIT];

  // Per-port selection and forced-off condition.
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      assign port_hit[g] = wr_port_ctl && (port_sel == 4'(g));
    end
  endgenerate
  assign forced_off = PORT_DISABLED & hard_off_r;
  assign loop_clr   = PORT_DISCONNECT | {NUM_PORTS{BUS_RESET}};

  // Port page byte for the selected port.
  assign port_byte = {port_bit(PORT_DISABLED, port_sel), port_bit(PORT_SLEEPING, port_sel),
                      port_bit(receive_ok_flag_r, port_sel), port_bit(con_r, port_sel),
                      port_bit(hard_off_r, port_sel), port_bit(standby_r, port_sel),
                      port_bit(loop_blk_r, port_sel), port_bit(sleep_en_r, port_sel)};

  // Identification page contents; read only, no write path exists.
  assign ident_byte = (REG_ADDR == pprp_pkg::CONFORM_ADDR)  ? pprp_pkg::CONFORM_LEVEL :
                      (REG_ADDR == pprp_pkg::MAKER_HI_ADDR) ? MAKER_CODE[23:16] :
                      (REG_ADDR == pprp_pkg::MAKER_MD_ADDR) ? MAKER_CODE[15:8] :
                      (REG_ADDR == pprp_pkg::MAKER_LO_ADDR) ? MAKER_CODE[7:0] :
                      (REG_ADDR == pprp_pkg::PART_HI_ADDR)  ? PART_CODE[23:16] :
                      (REG_ADDR == pprp_pkg::PART_MD_ADDR)  ? PART_CODE[15:8] :
                      (REG_ADDR == pprp_pkg::PART_LO_ADDR)  ? PART_CODE[7:0] :
                      8'h00;

  // Read selection; the vendor page, spare and unmapped addresses read zero.
  assign rd_mux = (REG_ADDR == pprp_pkg::BASE_SEL_ADDR) ? base_sel_r :
                  (on_port_pg && port_ok && (REG_ADDR == pprp_pkg::PORT_CTL_ADDR)) ? port_byte :
                  on_ident_pg ? ident_byte :
                  8'h00;

  // Monitor mode view of the sleep states.
  assign monitor_on = LINK_CLOCK_MONITOR_PIN;
  assign sleep_view = {{(8-NUM_PORTS){1'b0}}, PORT_SLEEPING};

  // Soft hard-reset request; it clears itself on the next edge, so it lasts one cycle.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      soft_rst_r <= 1'b0;
    end else if (soft_rst_r) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_soft_rst;
    end
  end

  // Page and port selection register.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      base_sel_r <= pprp_pkg::BASE_SEL_RST;
    end else if (wr_base_sel) begin
      base_sel_r <= REG_WDATA;
    end
  end

  // Sleep enables: strap caught during reset, then per-port writes.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      sleep_en_r <= {NUM_PORTS{SLEEP_STRAP_PIN}};
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (port_hit[i]) begin
          sleep_en_r[i] <= REG_WDATA[pprp_pkg::SLEEP_EN_BIT];
        end
      end
    end
  end

  // Forced-off controls, written per port.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      hard_off_r <= {NUM_PORTS{pprp_pkg::HARD_OFF_RST}};
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (port_hit[i]) begin
          hard_off_r[i] <= REG_WDATA[pprp_pkg::HARD_OFF_BIT];
        end
      end
    end
  end

  // Loop-block flag: a new block wins over a clear in the same cycle.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      loop_blk_r <= '0;
    end else begin
      loop_blk_r <= PORT_LOOP_BLOCK | (loop_blk_r & ~loop_clr);
    end
  end

  // Standby flag tracks the port state.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      standby_r <= '0;
    end else begin
      standby_r <= PORT_STANDBY;
    end
  end

  // Connection flags and tones gated by the forced-off condition.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      con_r  <= '0;
      receive_ok_flag_r <= '0;
      tone_r <= '0;
    end else begin
      con_r  <= PORT_CON_RAW & ~forced_off;
      receive_ok_flag_r <= PORT_RECEIVE_OK_FLAG_RAW & ~forced_off;
      tone_r <= ~forced_off;
    end
  end

  // Renegotiation pulse when a port leaves the forced-off condition.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      forced_off_r <= '0;
      reneg_r      <= '0;
    end else begin
      forced_off_r <= forced_off;
      reneg_r      <= forced_off_r & ~forced_off;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= REG_RD ? rd_mux : 8'h00;
    end
  end

  // Monitor data lines driven only in monitor mode.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      data_out_r  <= pprp_pkg::DATA_IDLE;
      data_oe_n_r <= 1'b1;
    end else begin
      data_out_r  <= monitor_on ? sleep_view : pprp_pkg::DATA_IDLE;
      data_oe_n_r <= !monitor_on;
    end
  end

  // Device reset output mirrors the internal reset, registered.
  always_ff @(posedge SYS_CLK) begin
    dev_rst_r <= rst;
  end

  // Reset seen one cycle late, so checks skip the first edge after any reset.
  always_ff @(posedge SYS_CLK) begin
    rst_dly_r <= rst;
  end
  assign chk_off = rst || rst_dly_r;

  // Output assignments straight from flip-flops.
  assign REG_RDATA        = rdata_r;
  assign PORT_CON         = con_r;
  assign RECEIVE_OK_FLAG  = receive_ok_flag_r;
  assign PORT_TONE_EN     = tone_r;
  assign PORT_RENEGOTIATE = reneg_r;
  assign PORT_SLEEP_EN    = sleep_en_r;
  assign DEVICE_RESET     = dev_rst_r;
  assign DATA_OUT         = data_out_r;
  assign DATA_OE_N        = data_oe_n_r;

  // Checks on the register bank.
  int unsigned rd_count;

  // Helper counter of reads seen, for cover use.
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      rd_count <= 0;
    end else if (REG_RD && rd_count < 8) begin
      rd_count <= rd_count + 1;
    end
  end

  strap_sample_a: assert property (@(posedge SYS_CLK)
    !RESET_N ##1 RESET_N |-> sleep_en_r == {NUM_PORTS{$past(SLEEP_STRAP_PIN)}})
    else $error("Sleep enables do not match strap.");

  sleep_single_a: assert property (@(posedge SYS_CLK) disable iff (rst)
    wr_port_ctl |=> (sleep_en_r & ~$past(port_hit)) == ($past(sleep_en_r) & ~$past(port_hit)))
    else $error("Sleep write disturbed another port.");

  monitor_out_a: assert property (@(posedge SYS_CLK) disable iff (chk_off)
    monitor_on |=> !DATA_OE_N && DATA_OUT[NUM_PORTS-1:0] == $past(PORT_SLEEPING))
    else $error("Monitor mode does not show sleep states.");

  loop_clear_a: assert property (@(posedge SYS_CLK) disable iff (rst)
    BUS_RESET && PORT_LOOP_BLOCK == '0 |=> loop_blk_r == '0)
    else $error("Loop-block flag survived a bus reset.");

  standby_track_a: assert property (@(posedge SYS_CLK) disable iff (chk_off)
    ##1 standby_r == $past(PORT_STANDBY))
    else $error("Standby flag does not follow the port.");

  forced_noeff_a: assert property (@(posedge SYS_CLK) disable iff (chk_off)
    PORT_DISABLED == '0 |=> con_r == $past(PORT_CON_RAW) && tone_r == '1)
    else $error("Forced-off acted on an enabled port.");

  disabled_keep_a: assert property (@(posedge SYS_CLK) disable iff (chk_off)
    (PORT_DISABLED & ~hard_off_r) != '0 |=> ((con_r ^ $past(PORT_CON_RAW))
      & $past(PORT_DISABLED & ~hard_off_r)) == '0)
    else $error("Disabled port lost its flag without its control bit.");

  forced_drop_a: assert property (@(posedge SYS_CLK) disable iff (rst)
    forced_off != '0 |=> (con_r & $past(forced_off)) == '0
      && (receive_ok_flag_r & $past(forced_off)) == '0 && (tone_r & $past(forced_off)) == '0)
    else $error("Forced-off port kept its flags or tones.");

  reneg_pulse_a: assert property (@(posedge SYS_CLK) disable iff (rst)
    $fell(forced_off[0]) |=> PORT_RENEGOTIATE[0] ##1 !PORT_RENEGOTIATE[0])
    else $error("No renegotiation pulse on release.");

  conform_read_a: assert property (@(posedge SYS_CLK) disable iff (rst)
    REG_RD && on_ident_pg && REG_ADDR == pprp_pkg::CONFORM_ADDR |=> REG_RDATA == 8'h02)
    else $error("Conformance level read wrong.");

  maker_read_a: assert property (@(posedge SYS_CLK) disable iff (rst)
    REG_RD && on_ident_pg && REG_ADDR == pprp_pkg::MAKER_HI_ADDR |=> REG_RDATA == MAKER_CODE[23:16])
    else $error("Maker code high byte read wrong.");

  part_read_a: assert property (@(posedge SYS_CLK) disable iff (rst)
    REG_RD && on_ident_pg && REG_ADDR == pprp_pkg::PART_HI_ADDR |=> REG_RDATA == PART_CODE[23:16])
    else $error("Part code high byte read wrong.");

  soft_reset_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    wr_soft_rst && !soft_rst_r |=> rst ##1 DEVICE_RESET && base_sel_r == pprp_pkg::BASE_SEL_RST)
    else $error("Soft reset did not reset the device.");

  soft_read_a: assert property (@(posedge SYS_CLK) disable iff (rst)
    REG_RD && on_vendor_pg |=> REG_RDATA == 8'h00)
    else $error("Vendor page read nonzero.");

  read_once_a: assert property (@(posedge SYS_CLK) disable iff (rst)
    !REG_RD |=> REG_RDATA == 8'h00)
    else $error("Read data outside its cycle.");

  ident_page_c: cover property (@(posedge SYS_CLK) disable iff (rst) REG_RD && on_ident_pg);
  vendor_rst_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) wr_soft_rst);
  forced_rel_c: cover property (@(posedge SYS_CLK) disable iff (rst) PORT_RENEGOTIATE != '0);
  monitor_c:    cover property (@(posedge SYS_CLK) disable iff (rst) monitor_on && rd_count > 2);

endmodule
`default_nettype wire

//--- shared/pprp_pkg.sv
// Constants shared by the paged PHY register bank.
package pprp_pkg;

  // Register address space: eight base registers, eight paged registers.
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;
  localparam int          NUM_PORTS     = 3;

  // Base register that holds page and port selection.
  localparam logic [3:0]  BASE_SEL_ADDR = 4'h7;
  localparam int          PAGE_LSB      = 5;
  localparam int          PAGE_W        = 3;
  localparam int          PORT_LSB      = 0;
  localparam int          PORT_W        = 4;
  localparam logic [7:0]  BASE_SEL_RST  = 8'h00;

  // Page numbers.
  localparam logic [2:0]  PAGE_PORT     = 3'h0;
  localparam logic [2:0]  PAGE_IDENT    = 3'h1;
  localparam logic [2:0]  PAGE_VENDOR   = 3'h7;

  // Port page: one status and control byte for the selected port.
  localparam logic [3:0]  PORT_CTL_ADDR = 4'h8;
  localparam int          SLEEP_EN_BIT  = 0;
  localparam int          LOOP_BLK_BIT  = 1;
  localparam int          STANDBY_BIT   = 2;
  localparam int          HARD_OFF_BIT  = 3;
  localparam int          CON_BIT       = 4;
  localparam int          RECEIVE_OK_FLAG_BIT      = 5;
  localparam int          SLEEPING_BIT  = 6;
  localparam int          DISABLED_BIT  = 7;
  localparam logic        HARD_OFF_RST  = 1'b0;

  // Identification page.
  localparam logic [3:0]  CONFORM_ADDR  = 4'h8;
  localparam logic [3:0]  ID_SPARE_ADDR = 4'h9;
  localparam logic [3:0]  MAKER_HI_ADDR = 4'ha;
  localparam logic [3:0]  MAKER_MD_ADDR = 4'hb;
  localparam logic [3:0]  MAKER_LO_ADDR = 4'hc;
  localparam logic [3:0]  PART_HI_ADDR  = 4'hd;
  localparam logic [3:0]  PART_MD_ADDR  = 4'he;
  localparam logic [3:0]  PART_LO_ADDR  = 4'hf;
  localparam logic [7:0]  CONFORM_LEVEL = 8'h02;

  // Vendor-dependent page: soft hard reset sits in the bit numbered 0, which is the MSB.
  localparam logic [3:0]  SOFT_RST_ADDR = 4'he;
  localparam int          SOFT_RST_BIT  = 7;

  // Idle value of the monitor data lines.
  localparam logic [7:0]  DATA_IDLE     = 8'h00;

endpackage

//--- sim/pprp_link_model.sv
// Link-controller model that reaches the PHY register bank.
`timescale 1ns/1ps
`default_nettype none
module pprp_link_model (
  // Clock.
  input  wire logic       clk,
  // Register port towards the PHY.
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  // The bus starts idle with both strobes low.
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One-cycle write; released data is inverted so a stale value cannot pass.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  // Read data is taken in the one cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Maps a page and a port into the paged window, reserved bit sent as zero.
  task automatic sel(input logic [2:0] pg, input logic [3:0] pt);
    wr_reg(pprp_pkg::BASE_SEL_ADDR, {pg, 1'b0, pt});
  endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the paged PHY register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Arbitrary identification values handed to the design.
  localparam logic [23:0] MK     = 24'h123456;
  localparam logic [23:0] PT     = 24'h654321;
  localparam logic [63:0] ID_EXP = {pprp_pkg::CONFORM_LEVEL, 8'h00, MK, PT};
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d, dout;
  logic       wr, rd, strap = 1'b1, mon = 1'b0, bus_rst = 1'b0, dev_rst, oe_n, f;
  logic [2:0] con_raw = 3'h0, receive_ok_flag_raw = 3'h0, loop = 3'h0, disc = 3'h0;
  logic [2:0] stby = 3'h0, slp = 3'h0, dis = 3'h0;
  logic [2:0] con, receive_ok_flag, tone, reneg, slp_en;
  int         compares = 0, miscompares = 0, cycles = 0;

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  pprp_regs #(.MAKER_CODE(MK), .PART_CODE(PT)) pprp_regs_i (
    .SYS_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SLEEP_STRAP_PIN(strap),
    .LINK_CLOCK_MONITOR_PIN(mon), .PORT_CON_RAW(con_raw), .PORT_RECEIVE_OK_FLAG_RAW(receive_ok_flag_raw),
    .PORT_LOOP_BLOCK(loop), .PORT_DISCONNECT(disc), .BUS_RESET(bus_rst),
    .PORT_STANDBY(stby), .PORT_SLEEPING(slp), .PORT_DISABLED(dis), .PORT_CON(con),
    .RECEIVE_OK_FLAG(receive_ok_flag), .PORT_TONE_EN(tone), .PORT_RENEGOTIATE(reneg),
    .PORT_SLEEP_EN(slp_en), .DEVICE_RESET(dev_rst), .DATA_OUT(dout), .DATA_OE_N(oe_n));

  pprp_link_model pprp_link_model_i (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compares one byte and reports a difference at once.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Lets settled outputs be sampled after n edges.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Reads the status and control byte of one port.
  task automatic rport(input logic [3:0] p, output logic [7:0] v);
    pprp_link_model_i.sel(pprp_pkg::PAGE_PORT, p);
    pprp_link_model_i.rd_reg(pprp_pkg::PORT_CTL_ADDR, v);
  endtask

  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wt(1);
    chk({7'h0, oe_n}, 8'h01);
    for (int p = 0; p < 3; p++) begin
      rport(p[3:0], d);
      chk(d & 8'h01, 8'h01);
    end
    chk({5'h0, slp_en}, 8'h07);
    pprp_link_model_i.sel(pprp_pkg::PAGE_PORT, 4'h1);
    pprp_link_model_i.wr_reg(pprp_pkg::PORT_CTL_ADDR, 8'h00);
    wt(2);
    chk({5'h0, slp_en}, 8'h05);
    @(posedge clk) loop <= 3'h4;
    @(posedge clk) loop <= 3'h0;
    rport(4'h2, d);
    chk(d & 8'h02, 8'h02);
    @(posedge clk) bus_rst <= 1'b1;
    @(posedge clk) bus_rst <= 1'b0;
    rport(4'h2, d);
    chk(d & 8'h02, 8'h00);
    @(posedge clk) loop <= 3'h4;
    @(posedge clk) loop <= 3'h0;
    @(posedge clk) disc <= 3'h4;
    @(posedge clk) disc <= 3'h0;
    rport(4'h2, d);
    chk(d & 8'h02, 8'h00);
    @(posedge clk) stby <= 3'h2;
    rport(4'h1, d);
    chk(d & 8'h04, 8'h04);
    rport(4'h0, d);
    chk(d & 8'h04, 8'h00);
    @(posedge clk) stby <= 3'h0;
    rport(4'h1, d);
    chk(d & 8'h04, 8'h00);
    // Identification page, then writes that must not stick.
    pprp_link_model_i.sel(pprp_pkg::PAGE_IDENT, 4'h0);
    for (int i = 0; i < 8; i++) begin
      pprp_link_model_i.rd_reg(4'h8 + i[3:0], d);
      chk(d, ID_EXP[63-8*i -: 8]);
    end
    pprp_link_model_i.wr_reg(pprp_pkg::MAKER_HI_ADDR, 8'hff);
    pprp_link_model_i.wr_reg(pprp_pkg::CONFORM_ADDR, 8'hff);
    pprp_link_model_i.rd_reg(pprp_pkg::MAKER_HI_ADDR, d);
    chk(d, MK[23:16]);
    pprp_link_model_i.rd_reg(pprp_pkg::CONFORM_ADDR, d);
    chk(d, pprp_pkg::CONFORM_LEVEL);
    // Forced-off control on port 0, enabled first and then disabled.
    @(posedge clk) con_raw <= 3'h7;
    receive_ok_flag_raw <= 3'h7;
    pprp_link_model_i.sel(pprp_pkg::PAGE_PORT, 4'h0);
    pprp_link_model_i.wr_reg(pprp_pkg::PORT_CTL_ADDR, 8'h08);
    wt(2);
    chk({2'h0, con, tone}, 8'h3f);
    // Port 1 is disabled as well, but its forced-off bit is clear.
    @(posedge clk) dis <= 3'h3;
    wt(3);
    chk({2'h0, con, receive_ok_flag}, 8'h36);
    chk({5'h0, tone}, 8'h06);
    @(posedge clk) dis <= 3'h0;
    f = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (reneg === 3'h1) f = 1'b1;
    end
    chk({7'h0, f}, 8'h01);
    // Monitor mode shows the sleep states on the data lines.
    @(posedge clk) mon <= 1'b1;
    slp <= 3'h5;
    wt(3);
    chk(dout, 8'h05);
    chk({7'h0, oe_n}, 8'h00);
    @(posedge clk) mon <= 1'b0;
    // Vendor page and the soft hard reset, with the strap now low.
    pprp_link_model_i.sel(pprp_pkg::PAGE_VENDOR, 4'h0);
    pprp_link_model_i.rd_reg(pprp_pkg::SOFT_RST_ADDR, d);
    chk(d, 8'h00);
    @(posedge clk) strap <= 1'b0;
    pprp_link_model_i.wr_reg(pprp_pkg::SOFT_RST_ADDR, 8'h80);
    f = 1'b0;
    repeat (5) begin
      @(posedge clk);
      #1;
      if (dev_rst === 1'b1) f = 1'b1;
    end
    chk({7'h0, f}, 8'h01);
    chk({5'h0, slp_en}, 8'h00);
    pprp_link_model_i.rd_reg(pprp_pkg::BASE_SEL_ADDR, d);
    chk(d, pprp_pkg::BASE_SEL_RST);
    pprp_link_model_i.sel(pprp_pkg::PAGE_VENDOR, 4'h0);
    pprp_link_model_i.rd_reg(pprp_pkg::SOFT_RST_ADDR, d);
    chk(d, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
